//--- hw/iwc_top.sv
// Interrupt, timer flag and standby control with an AXI4-Lite register slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module iwc_top
   import iwc_pkg::*;
#(
   parameter bit LEVEL_SENSE = 1'b1,
   parameter int LINES = 4
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   // External pins
   input wire logic reqPinN,
   input wire logic [LINES-1:0] portPin,
   input wire logic captureIn,
   input wire logic timerClkEn,
   // Core interface
   output logic vecValid,
   output logic [11:0] vecAddr,
   output logic maskBit,
   output logic coreHalted,
   output logic oscRun,
   // AXI4-Lite
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [1:0] pinSync;
      logic [LINES-1:0] portS1;
      logic [LINES-1:0] portS2;
      logic [1:0] capSync;
      logic capS3;
      logic pinPrev;
      logic pinLatch;
      logic [LINES-1:0] portFlags;
      logic [LINES-1:0] portEn;
      logic [2:0] tFlags;
      logic [2:0] tEn;
      logic [2:0] armed;
      logic [1:0] pre;
      logic [15:0] cnt;
      logic [15:0] cmp;
      logic [15:0] cap;
      logic cmpInhibit;
      logic capInhibit;
      logic mask;
      iwc_mode_e mode;
      logic vecV;
      logic [11:0] vec;
      logic awHave;
      logic [7:0] awA;
      logic wHave;
      logic [31:0] wD;
      logic bV;
      logic [1:0] bR;
      logic rV;
      logic [31:0] rD;
      logic [1:0] rR;
      logic halt;
      logic oscOn;
      logic [2:0] rdy;
   } iwc_state_s;

   iwc_state_s st_q;
   iwc_state_s st_d;

   // Valid register address decode, shared by both channels
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a[1:0] == 2'b00) && (a[7:2] inside {IDX_TIMER_CONTROL, IDX_TIMER_STATUS,
         IDX_CAP_HI, IDX_CAP_LO, IDX_CMP_HI, IDX_CMP_LO, IDX_CNT_HI, IDX_CNT_LO,
         IDX_PORT_FLAGS, IDX_PORT_ENABLES, IDX_CORE_CTRL, IDX_CORE_STATUS});
   endfunction : isMapped

   logic pinLow;
   logic pinFall;
   logic [LINES-1:0] portLow;
   logic pinReq;
   logic timerReq;
   logic portReq;
   logic anyReq;
   logic deepWake;
   logic doWrite;
   logic doRead;
   logic [5:0] wIdx;
   logic [5:0] rIdx;
   logic [7:0] wb;
   logic tick;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      st_d = st_q;
      // Pins pass two flops before use
      st_d.pinSync = {st_q.pinSync[0], reqPinN};
      st_d.portS1 = portPin;
      st_d.portS2 = st_q.portS1;
      st_d.capSync = {st_q.capSync[0], captureIn};
      st_d.capS3 = st_q.capSync[1];
      pinLow = !st_q.pinSync[1];
      pinFall = st_q.pinPrev && pinLow;
      st_d.pinPrev = st_q.pinSync[1];
      portLow = ~st_q.portS2;
      st_d.vecV = 1'b0;
      // Pin trigger: edge always latches; level adds a live term
      pinReq = st_q.pinLatch || (LEVEL_SENSE && pinLow);
      timerReq = |(st_q.tFlags & st_q.tEn);
      portReq = |(st_q.portFlags & st_q.portEn);
      anyReq = pinReq || timerReq || portReq;
      // Timer only wakes deep standby when its own clock is present
      deepWake = pinReq || portReq || (timerClkEn && |(st_q.tFlags[1:0] & st_q.tEn[1:0]));
      if (pinFall) begin
         st_d.pinLatch = 1'b1;
      end
      // Port flags follow a low pin whatever the enables
      st_d.portFlags = st_q.portFlags | portLow;
      // Prescaler divides by four; counter runs unless deep standby without timer clock
      tick = 1'b0;
      if (st_q.mode != DEEP || timerClkEn) begin
         st_d.pre = st_q.pre + 2'h1;
         tick = (st_q.pre == PRESCALE_LAST);
      end
      if (tick) begin
         st_d.cnt = st_q.cnt + 16'h0001;
         if (st_q.cnt == 16'hFFFF) begin
            st_d.tFlags[BIT_ROLLOVER-5] = 1'b1;
         end
         if (!st_q.cmpInhibit && st_q.cnt == st_q.cmp) begin
            st_d.tFlags[BIT_COMPARE-5] = 1'b1;
         end
      end
      if (st_q.capSync[1] && !st_q.capS3 && !st_q.capInhibit) begin
         st_d.cap = st_q.cnt + 16'h0001;
         st_d.tFlags[BIT_CAPTURE-5] = 1'b1;
      end
      // Standby exit; ordinary vectors, no wake mark
      if (st_q.mode == LIGHT && anyReq) begin
         st_d.mode = RUN;
      end
      if (st_q.mode == DEEP && deepWake) begin
         st_d.mode = RUN;
      end
      // Arbitration when mask clear and running: pin, timer, port
      if (st_q.mode == RUN && !st_q.mask && anyReq) begin
         st_d.mask = 1'b1;
         st_d.vecV = 1'b1;
         if (pinReq) begin
            st_d.vec = VEC_PIN;
            st_d.pinLatch = pinFall; // Early clear keeps one new edge
         end else if (timerReq) begin
            st_d.vec = VEC_TIMER;
         end else begin
            st_d.vec = VEC_PORT;
         end
      end
      // AXI write channel capture
      st_d.awHave = st_q.awHave || s_axi_awvalid;
      if (s_axi_awvalid && !st_q.awHave) begin
         st_d.awA = s_axi_awaddr;
      end
      st_d.wHave = st_q.wHave || s_axi_wvalid;
      if (s_axi_wvalid && !st_q.wHave) begin
         st_d.wD = s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      doWrite = st_q.awHave && st_q.wHave && !st_q.bV;
      wIdx = st_q.awA[7:2];
      wb = st_q.wD[7:0];
      if (s_axi_bvalid && s_axi_bready) begin
         st_d.bV = 1'b0;
      end
      if (doWrite) begin
         st_d.awHave = 1'b0;
         st_d.wHave = 1'b0;
         st_d.bV = 1'b1;
         st_d.bR = isMapped(st_q.awA) ? 2'b00 : 2'b10;
         if (st_q.awA[1:0] == 2'b00) begin
            case (wIdx)
               IDX_TIMER_CONTROL[5:0]: begin
                  st_d.tEn = wb[7:5];
               end
               IDX_CMP_HI[5:0]: begin
                  st_d.cmp[15:8] = wb;
                  st_d.cmpInhibit = 1'b1;
               end
               IDX_CMP_LO[5:0]: begin
                  st_d.cmp[7:0] = wb;
                  st_d.cmpInhibit = 1'b0;
                  if (st_q.armed[1]) begin
                     st_d.tFlags[1] = tick && !st_q.cmpInhibit && st_q.cnt == st_q.cmp;
                     st_d.armed[1] = 1'b0;
                  end
               end
               IDX_PORT_FLAGS[5:0]: begin
                  // Low pin sets the flag back at once
                  st_d.portFlags = (st_q.portFlags & ~wb[LINES-1:0]) | portLow;
               end
               IDX_PORT_ENABLES[5:0]: begin
                  st_d.portEn = wb[LINES-1:0];
               end
               IDX_CORE_CTRL[5:0]: begin
                  if (wb[CTL_MASK_CLR]) begin
                     st_d.mask = 1'b0; // Return from handler
                  end
                  if (wb[CTL_PIN_CLR]) begin
                     st_d.pinLatch = pinFall;
                  end
                  if (wb[CTL_SOFT_TRAP]) begin
                     st_d.vecV = 1'b1; // Taken whatever the mask
                     st_d.vec = VEC_SOFT;
                     st_d.mask = 1'b1;
                  end else if (wb[CTL_DEEP]) begin
                     st_d.mode = DEEP;
                     st_d.mask = 1'b0;
                  end else if (wb[CTL_LIGHT]) begin
                     st_d.mode = LIGHT;
                     st_d.mask = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // AXI read channel
      doRead = s_axi_arvalid && !st_q.rV;
      rIdx = s_axi_araddr[7:2];
      if (s_axi_rvalid && s_axi_rready) begin
         st_d.rV = 1'b0;
      end
      if (doRead) begin
         st_d.rV = 1'b1;
         st_d.rR = isMapped(s_axi_araddr) ? 2'b00 : 2'b10;
         st_d.rD = 32'h00000000;
         if (s_axi_araddr[1:0] == 2'b00) begin
            case (rIdx)
               IDX_TIMER_CONTROL[5:0]: st_d.rD[7:5] = st_q.tEn;
               IDX_TIMER_STATUS[5:0]: begin
                  st_d.rD[7:5] = st_q.tFlags;
                  st_d.armed = st_q.tFlags; // Arm flags seen set
               end
               IDX_CAP_HI[5:0]: begin
                  st_d.rD[7:0] = st_q.cap[15:8];
                  st_d.capInhibit = 1'b1;
               end
               IDX_CAP_LO[5:0]: begin
                  st_d.rD[7:0] = st_q.cap[7:0];
                  st_d.capInhibit = 1'b0;
                  if (st_q.armed[2]) begin
                     st_d.tFlags[2] = st_q.capSync[1] && !st_q.capS3 && !st_q.capInhibit;
                     st_d.armed[2] = 1'b0;
                  end
               end
               IDX_CMP_HI[5:0]: st_d.rD[7:0] = st_q.cmp[15:8];
               IDX_CMP_LO[5:0]: st_d.rD[7:0] = st_q.cmp[7:0];
               IDX_CNT_HI[5:0]: st_d.rD[7:0] = st_q.cnt[15:8];
               IDX_CNT_LO[5:0]: begin
                  st_d.rD[7:0] = st_q.cnt[7:0];
                  if (st_q.armed[0]) begin
                     // Set wins when rollover lands in the same cycle
                     st_d.tFlags[0] = tick && st_q.cnt == 16'hFFFF;
                     st_d.armed[0] = 1'b0;
                  end
               end
               IDX_PORT_FLAGS[5:0]: st_d.rD[LINES-1:0] = st_q.portFlags;
               IDX_PORT_ENABLES[5:0]: st_d.rD[LINES-1:0] = st_q.portEn;
               IDX_CORE_STATUS[5:0]: st_d.rD[7:0] = {anyReq, pinReq, timerReq, portReq,
                  st_q.mask, st_q.pinLatch, 2'b00};
               default: begin
               end
            endcase
         end
      end
      st_d.halt = (st_d.mode != RUN); // Output flops mirror next state
      st_d.oscOn = (st_d.mode != DEEP);
      st_d.rdy = {!st_d.awHave, !st_d.wHave, !st_d.rV};
   end

   // ************************************************************
   // Registers; reset values for control state
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.pinSync <= 2'b11;
         st_q.pinPrev <= 1'b1;
         st_q.portS1 <= '1;
         st_q.portS2 <= '1;
         st_q.cnt <= COUNT_RESET;
         st_q.mask <= 1'b1;
         st_q.mode <= RUN;
         st_q.vecV <= 1'b1;
         st_q.vec <= VEC_RESET;
         st_q.oscOn <= 1'b1;
         st_q.rdy <= 3'b111;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // Outputs straight from flops
   // ************************************************************
   assign vecValid = st_q.vecV;
   assign vecAddr = st_q.vec;
   assign maskBit = st_q.mask;
   assign coreHalted = st_q.halt;
   assign oscRun = st_q.oscOn;
   assign s_axi_awready = st_q.rdy[2];
   assign s_axi_wready = st_q.rdy[1];
   assign s_axi_bvalid = st_q.bV;
   assign s_axi_bresp = st_q.bR;
   assign s_axi_arready = st_q.rdy[0];
   assign s_axi_rvalid = st_q.rV;
   assign s_axi_rdata = st_q.rD;
   assign s_axi_rresp = st_q.rR;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence sAccept;
      clkEn && st_q.mode == RUN && !st_q.mask && anyReq;
   endsequence

   a_accept_sets_mask: assert property (sAccept |=> maskBit && vecValid)
      else $error("Accepted request did not set mask");
   a_pin_first: assert property (sAccept and pinReq |=> vecAddr == VEC_PIN)
      else $error("Pin request not served first");
   a_timer_second: assert property (sAccept and !pinReq && timerReq |=> vecAddr == VEC_TIMER)
      else $error("Timer vector wrong");
   a_port_vector: assert property (sAccept and !pinReq && !timerReq |=> vecAddr == VEC_PORT)
      else $error("Port vector wrong");
   a_masked_quiet: assert property (clkEn && maskBit && !(doWrite && wb[CTL_SOFT_TRAP]
      && wIdx == IDX_CORE_CTRL[5:0]) |=> !vecValid)
      else $error("Vector issued while masked");
   a_port_flag_low: assert property (clkEn && portLow != '0 |=> (st_q.portFlags & $past(portLow)) == $past(portLow))
      else $error("Low pin did not set port flag");
   a_deep_osc: assert property (clkEn && st_q.mode == RUN && doWrite && wIdx == IDX_CORE_CTRL[5:0]
      && wb[CTL_DEEP] && !wb[CTL_SOFT_TRAP] |=> !oscRun && !maskBit)
      else $error("Deep standby entry wrong");
   a_light_wake: assert property (clkEn && st_q.mode == LIGHT && anyReq |=> !coreHalted)
      else $error("Light standby did not end");
   a_write_resp: assert property (clkEn && doWrite |=> s_axi_bvalid)
      else $error("No write response");
endmodule : iwc_top

//--- shared/iwc_pkg.sv
// Constants and types for the interrupt and wake control block
// How it works
// - Soft trap is taken regardless of mask, vectors through 0xFFC/0xFFD.
// - Wake uses ordinary vectors; no wake indication is given.
// - Low request pin with mask clear is taken via 0xFFA/0xFFB, mask set.
// - Pin trigger is fixed: level plus falling edge, or falling edge only.
// - Pin latch cleared early in service; one further edge may stay pending.
// - With level sensing, a still-low pin after service raises a new request.
// - Capture, compare, rollover flags in top three status bits share 0xFF8.
// - Each timer flag has an enable; reset clears all three enables.
// - Timer request reaches the core only with mask clear; accept sets mask.
// - Flag clears on associated access after status read saw it set.
// - Four port lines share vector 0xFF6, one flag per line.
// - Port flag sets whenever its pin is low, driven or external.
// - Port flags clear only by write, reset; set regardless of enables.
// - Enabled line with flag high and mask clear raises a request.
// - Request drops with enable or flag; low pin resets flag at once.
// - Deep standby stops oscillator and processing, clears mask, keeps state.
// - Deep standby ends on pin, enabled port, reset, or rollover/compare timer flag with timer clock.
// - Light standby halts core, timer keeps running, mask cleared.
// - Light standby ends on any enabled interrupt or reset, vector 0xFF6..0xFFF.
// - Timer counter advances through a divide-by-four prescaler.
// - High-byte access inhibits a timer function until its low byte.
// - Cleared enable blocks the request but never the flag.
// - Reset sets mask, clears port enables, pin latch and standby latches.
package iwc_pkg;
   // ************************************************************
   // Register indices; the bus byte address is four times the index
   // ************************************************************
   localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
   localparam logic [7:0] IDX_TIMER_STATUS = 8'h13;
   localparam logic [7:0] IDX_CAP_HI = 8'h14;
   localparam logic [7:0] IDX_CAP_LO = 8'h15;
   localparam logic [7:0] IDX_CMP_HI = 8'h16;
   localparam logic [7:0] IDX_CMP_LO = 8'h17;
   localparam logic [7:0] IDX_CNT_HI = 8'h18;
   localparam logic [7:0] IDX_CNT_LO = 8'h19;
   localparam logic [7:0] IDX_PORT_FLAGS = 8'h20;
   localparam logic [7:0] IDX_PORT_ENABLES = 8'h21;
   localparam logic [7:0] IDX_CORE_CTRL = 8'h22;
   localparam logic [7:0] IDX_CORE_STATUS = 8'h23;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_CAPTURE = 7;
   localparam int BIT_COMPARE = 6;
   localparam int BIT_ROLLOVER = 5;
   localparam int CTL_MASK_CLR = 0;
   localparam int CTL_SOFT_TRAP = 1;
   localparam int CTL_DEEP = 2;
   localparam int CTL_LIGHT = 3;
   localparam int CTL_ACK = 4;
   localparam int CTL_PIN_CLR = 5;
   // ************************************************************
   // Vectors, reset values, timing
   // ************************************************************
   localparam logic [11:0] VEC_RESET = 12'hFFE;
   localparam logic [11:0] VEC_SOFT = 12'hFFC;
   localparam logic [11:0] VEC_PIN = 12'hFFA;
   localparam logic [11:0] VEC_TIMER = 12'hFF8;
   localparam logic [11:0] VEC_PORT = 12'hFF6;
   localparam logic [15:0] COUNT_RESET = 16'hFFFC;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam int HANDLER_GAP_CYCLES = 21;
   typedef enum logic [1:0] {RUN, LIGHT, DEEP} iwc_mode_e;
endpackage : iwc_pkg

//--- testbench/iwc_core_model.sv
// Model of the core sequencer and the request sources around the block
`timescale 1ns/10ps
module iwc_core_model
   import iwc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Commands from the bench
   input wire logic pinLow,
   input wire logic [3:0] portLow,
   input wire logic capHigh,
   // Pins toward the block
   output logic reqPinN,
   output logic [3:0] portPin,
   output logic captureIn,
   // Vector fetches seen by the core
   input wire logic vecValid,
   input wire logic [11:0] vecAddr,
   output logic [7:0] vecCount,
   output logic [11:0] lastVec
);
   // ************************************************************
   // Request lines: pulled up, so a released line reads high
   // ************************************************************
   // Bench spaces pin edges four cycles apart, inside a running handler
   assign reqPinN = ~pinLow;
   assign portPin = ~portLow;
   assign captureIn = capHigh; // Capture level straight from the bench
   // Fetch log; the reset-time vector is counted too, so only deltas matter
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vecCount <= 8'h00;
         lastVec <= VEC_RESET;
      end else if (vecValid === 1'b1) begin
         vecCount <= vecCount + 8'h01;
         lastVec <= vecAddr;
      end
   end
endmodule : iwc_core_model

//--- testbench/test_interrupt_and_wake_control.sv
// Self-checking bench for the interrupt and wake control block
`timescale 1ns/10ps
module test_interrupt_and_wake_control
   import iwc_pkg::*;
;
   // ************************************************************
   // Signals, addresses, helpers
   // ************************************************************
   localparam int CYCLE_LIMIT = 20000;
   localparam logic [7:0] AD_TCTL = {IDX_TIMER_CONTROL[5:0], 2'b00};
   localparam logic [7:0] AD_TSTAT = {IDX_TIMER_STATUS[5:0], 2'b00};
   localparam logic [7:0] AD_CNTLO = {IDX_CNT_LO[5:0], 2'b00};
   localparam logic [7:0] AD_PFLG = {IDX_PORT_FLAGS[5:0], 2'b00};
   localparam logic [7:0] AD_PEN = {IDX_PORT_ENABLES[5:0], 2'b00};
   localparam logic [7:0] AD_CORE = {IDX_CORE_CTRL[5:0], 2'b00};
   localparam logic [31:0] RET = 32'h1 << CTL_MASK_CLR;
   localparam logic [31:0] RET_PIN = RET | (32'h1 << CTL_PIN_CLR);
   logic ref_clk, rstn, pinLow, reqPinN, captureIn, timerClkEn, capHigh;
   logic [3:0] portLow, portPin;
   logic vecValid, maskBit, coreHalted, oscRun;
   logic [11:0] vecAddr, lastVec;
   logic [7:0] vecCount, mark;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
   int n_mismatch, check_count, cycles;

   iwc_top #(.LEVEL_SENSE(1'b1), .LINES(4)) DUT (
      .ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .reqPinN(reqPinN), .portPin(portPin),
      .captureIn(captureIn), .timerClkEn(timerClkEn), .vecValid(vecValid), .vecAddr(vecAddr),
      .maskBit(maskBit), .coreHalted(coreHalted), .oscRun(oscRun),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   iwc_core_model partner (
      .ref_clk(ref_clk), .rstn(rstn), .pinLow(pinLow), .portLow(portLow), .reqPinN(reqPinN),
      .portPin(portPin), .captureIn(captureIn), .vecValid(vecValid), .vecAddr(vecAddr),
      .vecCount(vecCount), .lastVec(lastVec), .capHigh(capHigh));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Hang guard: a stuck handshake ends the run as a failure
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == CYCLE_LIMIT) begin
         n_mismatch++;
         results();
      end
   end

   task results;
      $display("Counts: %0d compares, %0d mismatches", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Leading edge wait keeps two drives of one strobe out of one time step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      lastResp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rdData = s_axi_rdata;
      lastResp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      rd(a);
      chk(rdData & m, exp);
   endtask : rdChk

   // Exactly one fetch since mark, of the given vector, mask set
   task automatic waitVec(input logic [11:0] exp);
      int n;
      n = 0;
      while (vecCount === mark && n < 80) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (2) @(posedge ref_clk);
      chk(vecCount, mark + 8'h01);
      chk(lastVec, exp);
      chk(maskBit, 1'b1);
   endtask : waitVec

   task automatic quiet;
      repeat (8) @(posedge ref_clk);
      chk(vecCount, mark);
   endtask : quiet

   // Two counter samples sixteen clocks apart: four ticks when running
   task automatic cntStep(input logic [7:0] exp);
      logic [7:0] held;
      logic [7:0] diff;
      rd(AD_CNTLO);
      held = rdData[7:0];
      repeat (13) @(posedge ref_clk);
      rd(AD_CNTLO);
      diff = rdData[7:0] - held;
      chk(diff, exp);
   endtask : cntStep

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rstn = 1'b0;
      pinLow = 1'b0;
      portLow = 4'h0;
      timerClkEn = 1'b1;
      capHigh = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      n_mismatch = 0;
      check_count = 0;
      cycles = 0;
      mark = 8'h00;
      repeat (16) @(posedge ref_clk);
      chk(vecValid, 1'b1);
      chk(vecAddr, VEC_RESET);
      chk(maskBit, 1'b1);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdChk(AD_TCTL, 32'hFF, 32'h0);
      rdChk(AD_PEN, 32'hFF, 32'h0);
      rd(8'hFC);
      chk(lastResp, 2'h2);
      $display("test reset done");
      // Trap is taken with the mask set
      mark = vecCount;
      wr(AD_CORE, 32'h1 << CTL_SOFT_TRAP);
      waitVec(VEC_SOFT);
      // Low pin waits for the mask, then again while held low
      mark = vecCount;
      pinLow <= 1'b1;
      quiet();
      wr(AD_CORE, RET);
      waitVec(VEC_PIN);
      mark = vecCount;
      wr(AD_CORE, RET_PIN);
      waitVec(VEC_PIN);
      pinLow <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pinLow <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pinLow <= 1'b0;
      mark = vecCount;
      wr(AD_CORE, RET);
      waitVec(VEC_PIN);
      mark = vecCount;
      wr(AD_CORE, RET);
      quiet();
      $display("test pin done");
      // Each port line: flag without enable, request, sticky low, clear
      for (int i = 0; i < 4; i++) begin
         mark = vecCount;
         portLow <= 4'h1 << i;
         quiet();
         rdChk(AD_PFLG, 32'h0F, 32'h1 << i);
         wr(AD_PEN, 32'h1 << i);
         waitVec(VEC_PORT);
         wr(AD_PFLG, 32'h1 << i);
         rdChk(AD_PFLG, 32'h0F, 32'h1 << i);
         portLow <= 4'h0;
         repeat (4) @(posedge ref_clk);
         wr(AD_PFLG, 32'h0F);
         rdChk(AD_PFLG, 32'h0F, 32'h0);
         wr(AD_PEN, 32'h0);
         wr(AD_CORE, RET);
      end
      $display("test port done");
      // Trap with the mask clear, then three sources pending at once
      mark = vecCount;
      wr(AD_CORE, 32'h1 << CTL_SOFT_TRAP);
      waitVec(VEC_SOFT);
      rdChk(AD_TSTAT, 32'h20, 32'h20);
      wr(AD_TCTL, 32'h20);
      rdChk(AD_TCTL, 32'hFF, 32'h20);
      pinLow <= 1'b1;
      portLow <= 4'h2;
      wr(AD_PEN, 32'h2);
      mark = vecCount;
      quiet();
      wr(AD_CORE, RET);
      waitVec(VEC_PIN);
      pinLow <= 1'b0;
      repeat (4) @(posedge ref_clk);
      mark = vecCount;
      wr(AD_CORE, RET_PIN);
      waitVec(VEC_TIMER);
      rdChk(AD_TSTAT, 32'h20, 32'h20);
      rd(AD_CNTLO);
      rdChk(AD_TSTAT, 32'h20, 32'h0);
      mark = vecCount;
      wr(AD_CORE, RET);
      waitVec(VEC_PORT);
      portLow <= 4'h0;
      repeat (4) @(posedge ref_clk);
      wr(AD_PFLG, 32'h0F);
      capHigh <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdChk(AD_TSTAT, 32'hA0, 32'h80);
      cntStep(8'h04);
      $display("test priority done");
      // Light standby left by an enabled port line
      wr(AD_PEN, 32'h1);
      wr(AD_CORE, 32'h1 << CTL_LIGHT);
      repeat (2) @(posedge ref_clk);
      chk(coreHalted, 1'b1);
      chk(maskBit, 1'b0);
      cntStep(8'h04);
      mark = vecCount;
      portLow <= 4'h1;
      waitVec(VEC_PORT);
      chk(coreHalted, 1'b0);
      portLow <= 4'h0;
      repeat (4) @(posedge ref_clk);
      wr(AD_PFLG, 32'h0F);
      wr(AD_PEN, 32'h0);
      $display("test light standby done");
      // Deep standby left by the request pin
      timerClkEn <= 1'b0;
      wr(AD_CORE, 32'h1 << CTL_DEEP);
      repeat (2) @(posedge ref_clk);
      chk(oscRun, 1'b0);
      chk(maskBit, 1'b0);
      cntStep(8'h00);
      mark = vecCount;
      pinLow <= 1'b1;
      waitVec(VEC_PIN);
      chk(oscRun, 1'b1);
      pinLow <= 1'b0;
      $display("test deep standby done");
      results();
   end
endmodule : test_interrupt_and_wake_control
